// ### batch_setup_sequencer_tb.sv
/*
 * Self-checking bench for bss_top: registers, batches both ways, timeout
 * and the calibration menu. Assumes a short second of 20 cycles.
 */
module batch_setup_sequencer_tb
   import bss_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, link = 0, go = 0;
   logic [3:0]  kb = 4'h0;
   logic        opt = 1'b1;
   logic [11:0] pa = 12'h000;
   logic [31:0] pwd = 32'h0, prd, rd;
   logic        prdy, perr, er, fp, r1, r2, alm_n, cal, bend;
   int          mismatches = 0, check_count = 0, cnt, q, i, d;
   int          cl[10][3] = '{'{1,6,0}, '{1,5,5}, '{3,0,1}, '{3,100,1},
      '{3,99,99}, '{4,0,1}, '{4,300000,200000}, '{5,4,0}, '{6,4,0}, '{2,3,3}};
   always #12.5 clk = ~clk;
   bss_top #(.TICK_CYCLES(20)) DUT (.SYS_CLK(clk), .RSTN(rstn), .PSEL(psel),
      .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
      .PREADY(prdy), .PSLVERR(perr), .KEY_STOP(kb[0]), .KEY_RUN(kb[1]),
      .KEY_DISP(kb[2]), .KEY_BSET(kb[3]), .CAL_LINK(link),
      .OPT_FITTED(opt), .FLOW_PULSE(fp), .RELAY1(r1), .RELAY2(r2),
      .FLOW_ALARM_N(alm_n), .CAL_MODE(cal), .BATCH_END(bend));
   bss_flow_model FM (.clk(clk), .go(go), .gap(120), .pulse(fp), .count(cnt));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
      @(posedge clk);
      psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= v;
      @(posedge clk);
      pen <= 1;
      @(posedge clk);
      while (prdy !== 1'b1) @(posedge clk);
      rd = prd;
      er = perr;
      psel <= 0;
      pen <= 0;
   endtask
   task par(input int n, input logic [31:0] v);
      apb(1'b1, A_PARB + 12'(4 * n), v);
   endtask
   task key(input int n);
      kb[n] <= 1'b1;
      repeat (8) @(posedge clk);
      kb[n] <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   task end_sim;
      if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      mismatches++;
      end_sim;
   end
   initial begin
      void'($urandom(27996));
      repeat (20) @(posedge clk);
      rstn <= 1;
      repeat (4) @(posedge clk);
      apb(0, A_STAT, 0); chk(rd, 32'h00000020);
      apb(0, 12'h020, 0); chk({31'h0, er}, 32'h1);
      apb(0, A_PARB + 12'h00C, 0); chk(rd, FILT_MIN);
      apb(0, A_PARB + 12'h010, 0); chk(rd, CONV_ONE);
      for (i = 0; i < 10; i++) begin
         par(cl[i][0], cl[i][1]);
         apb(0, A_PARB + 12'(4 * cl[i][0]), 0);
         chk(rd, cl[i][2]);
      end
      par(4, CONV_ONE);
      par(8, 50);
      apb(1, A_QTY, 51); apb(0, A_QTY, 0); chk(rd, 0);
      apb(0, A_STAT, 0); chk(rd[1], 1);
      q = 4 + $urandom % 6;
      apb(1, A_QTY, q); apb(0, A_QTY, 0); chk(rd, q);
      par(10, 2); par(11, 2);
      for (d = 1; d >= 0; d--) begin
         par(12, d);
         apb(1, A_STAT, 3);
         if (d == 0) begin
            apb(1, A_CTRL, 1); repeat (10) @(posedge clk); chk(r1, 0);
            apb(1, A_CTRL, 4);
         end
         apb(1, A_CTRL, 1); repeat (10) @(posedge clk); chk(r1, 1);
         chk(r2, 0);
         go <= 1;
         for (i = 1; i <= q; i++) begin
            while (cnt < i) @(posedge clk);
            repeat (40) @(posedge clk);
            apb(0, A_BTOT, 0); chk(rd, d ? q - i : i);
            chk(r2, (i < q) && (q - i > 2));
         end
         go <= 0;
         chk(bend, 1); chk(r1, 0);
         while (cnt != 0) @(posedge clk);
      end
      par(13, 1); par(15, 1);
      apb(1, A_CTRL, 1); repeat (10) @(posedge clk); chk(r1, 1);
      repeat (80) @(posedge clk);
      chk(alm_n, 0); chk(r1, 0);
      key(K_STOP); chk(alm_n, 1);
      link <= 1;
      repeat (10) @(posedge clk); chk(cal, 1);
      apb(0, A_STAT, 0); chk(rd[14:8], 7'h01);
      for (i = 1; i <= 5; i++) begin
         key(K_DISP); apb(0, A_STAT, 0); chk(rd[14:12], i % 5);
      end
      opt <= 1'b0;
      key(K_DISP); key(K_DISP); apb(0, A_STAT, 0); chk(rd[14:12], 3);
      key(K_DISP); key(K_DISP);
      key(K_STOP); apb(0, A_STAT, 0); chk(rd[10:8], 2);
      key(K_BSET);
      apb(0, A_RTOT, 0); chk(rd, 0);
      apb(0, A_ATOT, 0); chk(rd, 0);
      end_sim;
   end
endmodule

// ### bss_flow_model.sv
/*
 * Flowmeter model: one pulse of four cycles per gap while enabled.
 * Assumes the bench raises go only while a batch should see flow.
 */
module bss_flow_model (
   // Clock and control.
   input wire logic clk,
   input wire logic go,
   input wire logic [31:0] gap,
   // Meter side.
   output logic     pulse,
   output int       count
);
   timeunit 1ns;
   timeprecision 100ps;
   // The count restarts whenever flow is switched off.
   initial begin
      pulse = 1'b0;
      count = 0;
      forever begin
         @(posedge clk);
         if (!go) count <= 0;
         else begin
            pulse <= 1'b1;
            repeat (4) @(posedge clk);
            pulse <= 1'b0;
            count <= count + 1;
            repeat (gap) @(posedge clk);
         end
      end
   end
endmodule

// ### bss_pkg.sv
/*
 * Shared constants and types of the batch setup sequencer: register map,
 * parameter indexes, value limits, input bit positions and timing.
 * Assumes a single 40 MHz system clock and a 12-bit APB byte address.
 */
package bss_pkg;
   // Timing.
   localparam int unsigned CLK_HZ   = 40000000;
   localparam int unsigned TICK_S   = 1;
   localparam int unsigned TICK_CYC = TICK_S * CLK_HZ;
   localparam int unsigned HOLD_S   = 6;
   localparam logic [16:0] SEC_MIN  = 17'h0003C;
   // Register byte addresses.
   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_STAT = 12'h004;
   localparam logic [11:0] A_QTY  = 12'h008;
   localparam logic [11:0] A_RATE = 12'h00C;
   localparam logic [11:0] A_RTOT = 12'h010;
   localparam logic [11:0] A_ATOT = 12'h014;
   localparam logic [11:0] A_BTOT = 12'h018;
   localparam logic [11:0] A_PARB = 12'h040;
   localparam logic [11:0] A_PARL = 12'h07C;
   localparam int          PA_LO  = 2;
   localparam int          PA_HI  = 5;
   // Control and status bit positions.
   localparam int C_START = 0;
   localparam int C_STOP  = 1;
   localparam int C_CLR   = 2;
   localparam int ST_EOB  = 0;
   localparam int ST_REJ  = 1;
   // Parameter indexes.
   localparam logic [3:0] P_SCALE  = 4'h0;
   localparam logic [3:0] P_RDEC   = 4'h1;
   localparam logic [3:0] P_TBASE  = 4'h2;
   localparam logic [3:0] P_FILT   = 4'h3;
   localparam logic [3:0] P_CONV   = 4'h4;
   localparam logic [3:0] P_TDEC   = 4'h5;
   localparam logic [3:0] P_ADEC   = 4'h6;
   localparam logic [3:0] P_ACCESS = 4'h7;
   localparam logic [3:0] P_LIMIT  = 4'h8;
   localparam logic [3:0] P_RSTRT  = 4'h9;
   localparam logic [3:0] P_SLOW   = 4'hA;
   localparam logic [3:0] P_PREST  = 4'hB;
   localparam logic [3:0] P_DIR    = 4'hC;
   localparam logic [3:0] P_TOUT   = 4'hD;
   localparam logic [3:0] P_AOC    = 4'hE;
   localparam logic [3:0] P_ARST   = 4'hF;
   localparam int         RST_EN   = 16;
   // Value limits and reset values.
   localparam logic [31:0] RDEC_MAX = 32'h00000005;
   localparam logic [31:0] TDEC_MAX = 32'h00000003;
   localparam logic [31:0] FILT_MIN = 32'h00000001;
   localparam logic [31:0] FILT_MAX = 32'h00000063;
   localparam logic [31:0] CONV_MIN = 32'h00000001;
   localparam logic [31:0] CONV_ONE = 32'h00000064;
   localparam logic [31:0] CONV_MAX = 32'h00030D40;
   // Timebase codes and multipliers.
   localparam logic [1:0]  TB_MIN  = 2'h0;
   localparam logic [1:0]  TB_HOUR = 2'h1;
   localparam logic [1:0]  TB_DAY  = 2'h2;
   localparam logic [31:0] MUL_S   = 32'h00000001;
   localparam logic [31:0] MUL_M   = 32'h0000003C;
   localparam logic [31:0] MUL_H   = 32'h00000E10;
   localparam logic [31:0] MUL_D   = 32'h00015180;
   // Synchronised input bit positions.
   localparam int K_STOP  = 0;
   localparam int K_RUN   = 1;
   localparam int K_DISP  = 2;
   localparam int K_BSET  = 3;
   localparam int K_LINK  = 4;
   localparam int K_PULSE = 5;
   localparam int K_OPT   = 6;
   localparam int NIN     = 7;
   // Top menu selections.
   localparam logic [2:0] S_CAL = 3'h0;
   localparam logic [2:0] S_BAT = 3'h1;
   localparam logic [2:0] S_OPT = 3'h2;
   localparam logic [2:0] S_TST = 3'h3;
   localparam logic [2:0] S_END = 3'h4;
   localparam logic [3:0] CAL_LAST = 4'h8;
   localparam logic [3:0] BAT_LAST = 4'h7;
   localparam logic [3:0] BAT_ARST = 4'h7;

   typedef enum logic [2:0] {
      MN_NORM, MN_TOP, MN_CAL, MN_BAT, MN_AUX
   } bss_menu_t;
   typedef enum logic [1:0] {B_IDLE, B_RUN, B_DONE} bss_bat_t;
endpackage

// ### bss_props.sv
/*
 * Port checker for bss_top: bus timing, relay order, alarm and menu entry.
 * Assumes one clock SYS_CLK and a synchronous active-low RSTN.
 */
module bss_props (
   // Clock and reset.
   input wire logic        SYS_CLK,
   input wire logic        RSTN,
   // Bus.
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   // Pins.
   input wire logic        KEY_STOP,
   input wire logic        CAL_LINK,
   input wire logic        RELAY1,
   input wire logic        RELAY2,
   input wire logic        FLOW_ALARM_N,
   input wire logic        CAL_MODE,
   input wire logic        BATCH_END
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);
   sequence s_access;
      PSEL && PENABLE && !PREADY;
   endsequence
   sequence s_stop_quiet;
      !KEY_STOP [*8];
   endsequence
   AST_READY_NEXT: assert property (s_access |=> PREADY)
      else $error("ready late");
   AST_READY_PULSE: assert property (PREADY |=> !PREADY)
      else $error("ready held");
   AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   AST_RDATA_IDLE: assert property (!PREADY |-> PRDATA == 32'h0)
      else $error("read data outside ready");
   AST_RELAY2_NEEDS_1: assert property (RELAY2 |-> RELAY1)
      else $error("second stage alone");
   AST_END_DROPS: assert property ($rose(BATCH_END) |-> !RELAY1 && !RELAY2)
      else $error("relays on at end");
   AST_ALARM_STOPS: assert property ($fell(FLOW_ALARM_N) |-> ##[0:2] !RELAY1)
      else $error("relay on after timeout");
   AST_ALARM_HOLD: assert property (s_stop_quiet ##0 !FLOW_ALARM_N |=> !FLOW_ALARM_N)
      else $error("alarm cleared without stop");
   AST_CAL_ENTRY: assert property (CAL_LINK [*8] |-> CAL_MODE)
      else $error("link did not enter calibration");
   AST_RESET_QUIET: assert property (disable iff (1'b0)
      !RSTN |=> !RELAY1 && !RELAY2 && FLOW_ALARM_N && !PREADY)
      else $error("outputs active in reset");
endmodule

bind bss_top bss_props u_props (.SYS_CLK, .RSTN, .PSEL, .PENABLE, .PRDATA,
   .PREADY, .PSLVERR, .KEY_STOP, .CAL_LINK, .RELAY1, .RELAY2, .FLOW_ALARM_N,
   .CAL_MODE, .BATCH_END);

// ### bss_top.sv
/*
 * Batch setup sequencer: calibration menu driven by four front keys,
 * setup and batch parameters, rate and totals, two-stage valve control,
 * flow timeout alarm and an APB register slave.
 * Assumes asynchronous key, link and pulse pins and one 40 MHz clock.
 */
// The APB interface to the registers and the register addresses were chosen for this implementation.
module bss_top
   import bss_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC
)(
   // Clock and reset.
   input  wire logic        SYS_CLK,
   input  wire logic        RSTN,
   // APB slave.
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // Front keys, rear link, option strap and flow pulse.
   input  wire logic        KEY_STOP,
   input  wire logic        KEY_RUN,
   input  wire logic        KEY_DISP,
   input  wire logic        KEY_BSET,
   input  wire logic        CAL_LINK,
   input  wire logic        OPT_FITTED,
   input  wire logic        FLOW_PULSE,
   // Valve relays and indications.
   output logic             RELAY1,
   output logic             RELAY2,
   output logic             FLOW_ALARM_N,
   output logic             CAL_MODE,
   output logic             BATCH_END
);

   function automatic logic [31:0] fit(input logic [3:0]  i,
                                       input logic [31:0] v);
      logic [31:0] r;
      r = v;
      case (i)
         P_RDEC: if (v > RDEC_MAX) r = '0;
         P_TDEC: if (v > TDEC_MAX) r = '0;
         P_ADEC: if (v > TDEC_MAX) r = '0;
         P_TBASE: r = {30'h0, v[1:0]};
         P_FILT: if (v < FILT_MIN || v > FILT_MAX) r = FILT_MIN;
         P_CONV: begin
            if (v < CONV_MIN) r = CONV_MIN;
            else if (v > CONV_MAX) r = CONV_MAX;
         end
         P_ACCESS, P_DIR, P_AOC, P_ARST: r = {31'h0, v[0]};
         P_RSTRT: r = {15'h0, v[16:0]};
         P_SLOW: r = {16'h0, v[15:0]};
         P_TOUT: r = {16'h0, v[15:0]};
         default: r = v;
      endcase
      return r;
   endfunction

   function automatic logic [31:0] pdef(input logic [3:0] i);
      logic [31:0] r;
      r = '0;
      if (i == P_FILT) r = FILT_MIN;
      if (i == P_CONV) r = CONV_ONE;
      return r;
   endfunction

   function automatic logic [16:0] secs(input logic [15:0] v);
      return 17'(17'(v[15:8]) * SEC_MIN) + 17'(v[7:0]);
   endfunction

   function automatic logic [31:0] tmul(input logic [1:0] t);
      logic [31:0] r;
      case (t)
         TB_MIN:  r = MUL_M;
         TB_HOUR: r = MUL_H;
         TB_DAY:  r = MUL_D;
         default: r = MUL_S;
      endcase
      return r;
   endfunction

   // Input synchronisers; a level counts once stages two and three agree.
   logic [NIN-1:0] s1_q;
   logic [NIN-1:0] s2_q;
   logic [NIN-1:0] s3_q;
   logic [NIN-1:0] lv_q;
   logic [NIN-1:0] lp_q;
   logic [NIN-1:0] lv_d;
   logic [NIN-1:0] prs;
   logic [NIN-1:0] raw;
   assign raw = {OPT_FITTED, FLOW_PULSE, CAL_LINK, KEY_BSET, KEY_DISP,
                 KEY_RUN, KEY_STOP};
   assign lv_d = (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & lv_q);
   assign prs = lv_q & ~lp_q;

   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         lv_q <= '0;
         lp_q <= '0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lv_q <= lv_d;
         lp_q <= lv_q;
      end
   end

   // One-second tick.
   logic [31:0] div_q;
   logic        tick_q;
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else if (div_q == 32'(TICK_CYCLES - 1)) begin
         div_q  <= '0;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + 32'h1;
         tick_q <= 1'b0;
      end
   end

   // APB handshake: one wait state, write lands on the completing edge.
   logic        rd_ph;
   logic        wr;
   logic        hit;
   logic        wr_par;
   logic [3:0]  wa;
   logic [31:0] rdv;
   logic        cmd_go;
   logic        cmd_stop;
   logic        cmd_clr;
   assign rd_ph = PSEL & PENABLE & ~PREADY;
   assign wr = PSEL & PENABLE & PREADY & PWRITE;
   assign wa = PADDR[PA_HI:PA_LO];
   assign hit = (PADDR[PA_LO-1:0] == 2'h0) &&
                (PADDR <= A_BTOT || (PADDR >= A_PARB && PADDR <= A_PARL));
   assign wr_par = wr && hit && PADDR >= A_PARB;
   assign cmd_go = wr && PADDR == A_CTRL && PWDATA[C_START];
   assign cmd_stop = wr && PADDR == A_CTRL && PWDATA[C_STOP];
   assign cmd_clr = wr && PADDR == A_CTRL && PWDATA[C_CLR];

   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         PREADY  <= 1'b0;
         PRDATA  <= '0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= rd_ph;
         PRDATA  <= (rd_ph && !PWRITE && hit) ? rdv : '0;
         PSLVERR <= rd_ph & ~hit;
      end
   end

   // Parameters and menu state.
   logic [31:0] par_q [16];
   bss_menu_t   mode_q;
   logic [2:0]  sel_q;
   logic [3:0]  step_q;
   logic [2:0]  dig_q;
   logic [3:0]  hold_q;
   logic [3:0]  pidx;
   logic [31:0] cur;
   logic [31:0] nv;
   logic        edit;
   logic        rst_en;
   logic        enter;
   logic        nrm;
   logic [2:0]  nsel;
   assign nrm = mode_q == MN_NORM;
   assign pidx = (mode_q == MN_CAL) ? 4'(step_q - 4'h1)
                                    : 4'(step_q + P_LIMIT);
   assign edit = (mode_q == MN_CAL && step_q != 4'h0) || mode_q == MN_BAT;
   assign cur = par_q[pidx];
   assign rst_en = par_q[P_RSTRT][RST_EN];
   // Displayed digit is one nibble of the selected value.
   always_comb begin
      nv = cur;
      if (prs[K_BSET]) nv[{dig_q, 2'h0} +: 4] = 4'h0;
      else nv[{dig_q, 2'h0} +: 4] = 4'(cur[{dig_q, 2'h0} +: 4] + 4'h1);
   end
   assign nsel = (sel_q == S_END) ? S_CAL :
                 (sel_q == S_BAT && !lv_q[K_OPT]) ? S_TST :
                 3'(sel_q + 3'h1);
   assign enter = nrm && (lv_q[K_LINK] || hold_q >= 4'(HOLD_S));

   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         hold_q <= '0;
      end else if (lv_q[K_STOP] && lv_q[K_DISP] && !par_q[P_ACCESS][0]) begin
         if (tick_q && hold_q < 4'(HOLD_S)) hold_q <= hold_q + 4'h1;
      end else begin
         hold_q <= '0;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         for (int i = 0; i < 16; i++) par_q[i] <= pdef(4'(i));
      end else if (wr_par) begin
         par_q[wa] <= fit(wa, PWDATA);
      end else if (edit && (prs[K_DISP] || prs[K_BSET])) begin
         par_q[pidx] <= fit(pidx, nv);
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         mode_q <= MN_NORM;
         sel_q  <= S_CAL;
         step_q <= '0;
         dig_q  <= '0;
      end else begin
         if (prs[K_RUN]) dig_q <= 3'(dig_q + 3'h1);
         case (mode_q)
            MN_NORM: begin
               if (enter) begin
                  mode_q <= MN_TOP;
                  sel_q  <= S_CAL;
               end
            end
            MN_TOP: begin
               step_q <= '0;
               dig_q  <= '0;
               if (prs[K_STOP]) begin
                  case (sel_q)
                     S_CAL: mode_q <= MN_CAL;
                     S_BAT: mode_q <= MN_BAT;
                     S_OPT, S_TST: mode_q <= MN_AUX;
                     default: if (!lv_q[K_LINK]) mode_q <= MN_NORM;
                  endcase
               end else if (prs[K_DISP]) begin
                  sel_q <= nsel;
               end
            end
            MN_CAL: begin
               if (prs[K_STOP]) begin
                  dig_q <= '0;
                  step_q <= 4'(step_q + 4'h1);
                  if (step_q == CAL_LAST) begin
                     mode_q <= MN_TOP;
                     sel_q  <= S_END;
                  end
               end
            end
            MN_BAT: begin
               if (prs[K_STOP]) begin
                  dig_q <= '0;
                  step_q <= 4'(step_q + 4'h1);
                  if (step_q == BAT_LAST ||
                      (step_q == 4'(BAT_ARST - 4'h1) && rst_en)) begin
                     mode_q <= MN_TOP;
                     sel_q  <= S_END;
                  end
               end
            end
            MN_AUX: begin
               if (prs[K_STOP]) mode_q <= MN_TOP;
            end
            default: mode_q <= MN_NORM;
         endcase
      end
   end

   // Rate: pulses per second scaled to the timebase, then smoothed.
   logic [15:0] pc_q;
   logic [31:0] rate_q;
   logic [31:0] rraw;
   logic [31:0] filt;
   assign rraw = 32'(pc_q) * tmul(par_q[P_TBASE][1:0]);
   assign filt = par_q[P_FILT];
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         pc_q   <= '0;
         rate_q <= '0;
      end else if (tick_q) begin
         pc_q <= 16'(prs[K_PULSE]);
         if (rraw >= rate_q) rate_q <= rate_q + (rraw - rate_q) / filt;
         else rate_q <= rate_q - (rate_q - rraw) / filt;
      end else if (prs[K_PULSE] && pc_q != 16'hFFFF) begin
         pc_q <= pc_q + 16'h1;
      end
   end

   // Total units: hundredths per pulse are divided by the factor.
   logic [31:0] res_q;
   logic        unit_q;
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         res_q  <= '0;
         unit_q <= 1'b0;
      end else begin
         unit_q <= 1'b0;
         if (prs[K_PULSE]) begin
            res_q <= res_q + CONV_ONE;
         end else if (res_q >= par_q[P_CONV]) begin
            res_q  <= res_q - par_q[P_CONV];
            unit_q <= 1'b1;
         end
      end
   end

   logic [31:0] rtot_q;
   logic [31:0] atot_q;
   logic        clr_tot;
   assign clr_tot = mode_q == MN_CAL && step_q == 4'h0 && prs[K_BSET];
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN || clr_tot) begin
         rtot_q <= '0;
         atot_q <= '0;
      end else if (unit_q) begin
         rtot_q <= rtot_q + 32'h1;
         atot_q <= atot_q + 32'h1;
      end
   end

   // Flow idle time and timeout.
   logic [15:0] idle_q;
   logic [15:0] tout;
   logic        to_on;
   logic        tmo;
   logic        go;
   assign tout = par_q[P_TOUT][15:0];
   assign to_on = tout != 16'h0;
   assign tmo = to_on && idle_q > tout;
   // Idle time restarts with each batch, so only a stall inside it times out.
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN || prs[K_PULSE] || go) idle_q <= '0;
      else if (tick_q && idle_q != 16'hFFFF) idle_q <= idle_q + 16'h1;
   end

   // Batch sequencing.
   bss_bat_t    bst_q;
   logic [31:0] qty_q;
   logic [31:0] dlv_q;
   logic [31:0] tgt_q;
   logic [31:0] ovr_q;
   logic [16:0] el_q;
   logic [16:0] rs_q;
   logic        bclr_q;
   logic        arst;
   logic        aoc_on;
   logic        halt;
   logic [31:0] rem;
   logic [31:0] btot;
   assign arst = par_q[P_ARST][0] | rst_en;
   assign aoc_on = par_q[P_AOC][0] && to_on;
   assign go = (nrm && prs[K_RUN] || cmd_go ||
                (bst_q == B_DONE && rst_en &&
                 rs_q >= secs(par_q[P_RSTRT][15:0]))) &&
               bst_q != B_RUN && qty_q != 32'h0 &&
               (arst || bclr_q);
   assign halt = nrm && prs[K_STOP] || cmd_stop;
   assign rem = tgt_q - dlv_q;
   assign btot = par_q[P_DIR][0] ? qty_q - dlv_q : dlv_q;

   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         qty_q <= '0;
      end else if (wr && PADDR == A_QTY) begin
         if (par_q[P_LIMIT] == 32'h0 || PWDATA <= par_q[P_LIMIT]) begin
            qty_q <= PWDATA;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         bst_q  <= B_IDLE;
         dlv_q  <= '0;
         tgt_q  <= '0;
         ovr_q  <= '0;
         el_q   <= '0;
         bclr_q <= 1'b1;
      end else begin
         if (cmd_clr) begin
            dlv_q  <= '0;
            bclr_q <= 1'b1;
         end
         case (bst_q)
            B_IDLE, B_DONE: begin
               if (go) begin
                  bst_q  <= B_RUN;
                  dlv_q  <= '0;
                  bclr_q <= 1'b0;
                  el_q   <= '0;
                  tgt_q  <= (aoc_on && ovr_q < qty_q) ? qty_q - ovr_q
                                                      : qty_q;
               end else if (bst_q == B_DONE && unit_q && !tmo) begin
                  ovr_q <= ovr_q + 32'h1;
               end
            end
            B_RUN: begin
               if (tick_q && el_q != 17'h1FFFF) el_q <= el_q + 17'h1;
               if (unit_q) dlv_q <= dlv_q + 32'h1;
               if (halt || tmo) begin
                  bst_q <= B_IDLE;
               end else if (unit_q && dlv_q + 32'h1 >= tgt_q) begin
                  bst_q <= B_DONE;
                  ovr_q <= '0;
               end
            end
            default: bst_q <= B_IDLE;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RSTN || bst_q != B_DONE) rs_q <= '0;
      else if (tick_q && rs_q != 17'h1FFFF) rs_q <= rs_q + 17'h1;
   end

   // Relays follow the batch state one cycle later.
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         RELAY1 <= 1'b0;
         RELAY2 <= 1'b0;
      end else begin
         RELAY1 <= bst_q == B_RUN;
         RELAY2 <= bst_q == B_RUN &&
                   el_q >= secs(par_q[P_SLOW][15:0]) &&
                   rem > par_q[P_PREST];
      end
   end

   // Sticky flags; a new event beats a clear in the same cycle.
   logic eob_q;
   logic rej_q;
   logic w1c;
   logic ev_eob;
   logic ev_rej;
   assign w1c = wr && PADDR == A_STAT;
   assign ev_eob = bst_q == B_RUN && !halt && !tmo && unit_q &&
                   dlv_q + 32'h1 >= tgt_q;
   assign ev_rej = wr && PADDR == A_QTY && par_q[P_LIMIT] != 32'h0 &&
                   PWDATA > par_q[P_LIMIT];
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         eob_q <= 1'b0;
         rej_q <= 1'b0;
      end else begin
         eob_q <= ev_eob | (eob_q & ~(w1c & PWDATA[ST_EOB]));
         rej_q <= ev_rej | (rej_q & ~(w1c & PWDATA[ST_REJ]));
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         FLOW_ALARM_N <= 1'b1;
      end else if (bst_q == B_RUN && tmo) begin
         FLOW_ALARM_N <= 1'b0;
      end else if (prs[K_STOP]) begin
         FLOW_ALARM_N <= 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         CAL_MODE  <= 1'b0;
         BATCH_END <= 1'b0;
      end else begin
         CAL_MODE  <= !nrm;
         BATCH_END <= eob_q;
      end
   end

   // Read mux.
   always_comb begin
      rdv = '0;
      case (PADDR)
         A_STAT: rdv = {12'h0, step_q, 1'b0, sel_q, 1'b0, mode_q, bst_q,
                        bclr_q, ~FLOW_ALARM_N, RELAY2, RELAY1, rej_q,
                        eob_q};
         A_QTY:  rdv = qty_q;
         A_RATE: rdv = rate_q;
         A_RTOT: rdv = rtot_q;
         A_ATOT: rdv = atot_q;
         A_BTOT: rdv = btot;
         default: if (PADDR >= A_PARB) rdv = par_q[wa];
      endcase
   end
endmodule
